// ==== ddr_sram_byte_write_ports.sv ====
// Read and write ports of a burst-of-two DDR SRAM with per-lane ECC and impedance stepping.
// Assumes K, K#, C, C# and all data pins arrive asynchronously and far slower than i_sys_clk.
`timescale 1ns/10ps
`default_nettype none
`include "ddr_sram_ports_map.svh"

// Overview of operation
// (R1) Each lane mask is taken on the same clock edge as its data beat.
// (R2) A high mask keeps the stored byte; a low mask stores it.
// (R3) Every accepted write address carries two data beats.
// (R4) Any mix of lane masks is legal; each 9-bit lane is masked alone.
// (R5) A write masking exactly one beat of a lane turns ECC off for good.
// (R6) Masks 00 write both beats, 01 first only, 10 second only, 11 none.
// (R7) Mask lane k governs data bits 9k+8 down to 9k.
// (R8) A cycle counter periodically triggers an impedance evaluation, then restarts.
// (R9) Each evaluation moves the driver setting by at most one step.
// (R10) Read taken at K rise n; beats at C# rise n+1.5 and C rise n+2.
// (R11) A deselected read leaves the outputs high impedance for both beat slots.
// (R12) Write select and first beat at K rise; address and second beat at K#.
// (R13) All masks high aborts the write; write select high ignores everything.
// (R14) With both output clocks held high, K and K# time the outputs.
// (R15) Each two-beat lane word is guarded by a 5-bit single-error code.
// (R16) Beat addresses are the loaded address with a low bit of 0 then 1.
// (R17) With ECC off, words are stored and returned without correction.
// (R18) Read and write ports run concurrently and independently.
module ddr_sram_byte_write_ports #(
	parameter int LANES      = `LANES_DEFAULT,
	parameter int ADDR_BITS  = `ADDR_BITS,
	parameter int IMP_PERIOD = `IMP_PERIOD
) (
	input  wire logic                            i_sys_clk,
	input  wire logic                            i_resetn,
	input  wire logic                            i_k,
	input  wire logic                            i_k_n,
	input  wire logic                            i_c,
	input  wire logic                            i_c_n,
	input  wire logic                            i_read_sel_n,
	input  wire logic                            i_write_sel_n,
	input  wire logic [ADDR_BITS-1:0]            i_addr,
	input  wire logic [LANES*`LANE_BITS-1:0]     i_write_data,
	input  wire logic [LANES-1:0]                i_byte_write_enable_n,
	input  wire logic                            i_impedance_reference_pin,
	output var  logic [LANES*`LANE_BITS-1:0]     o_read_data,
	output var  logic                            o_read_data_oe_n,
	output var  ddr_sram_ports_pkg::drive_t      o_drive_setting,
	output var  logic                            o_ecc_enabled
);
	import ddr_sram_ports_pkg::*;

	localparam int DW    = LANES * `LANE_BITS;
	localparam int DEPTH = 1 << ADDR_BITS;
	localparam int CW    = $clog2(IMP_PERIOD);

	function automatic logic [`CHECK_BITS-1:0] hamming_check(input logic [2*`LANE_BITS-1:0] w);
		logic [`CHECK_BITS-1:0] s;
		int                     j;
		s = '0;
		j = 0;
		for (int p = 1; p <= `CODE_POSITIONS; p++) begin
			if ((p & (p - 1)) != 0) begin
				if (w[j])
					s = s ^ p[`CHECK_BITS-1:0];
				j++;
			end
		end
		return s;
	endfunction

	function automatic logic [2*`LANE_BITS-1:0] hamming_fix(input logic [2*`LANE_BITS-1:0] w,
			input logic [`CHECK_BITS-1:0] c, input logic en);
		logic [`CHECK_BITS-1:0]  syn;
		logic [2*`LANE_BITS-1:0] r;
		int                      j;
		syn = hamming_check(w) ^ c;
		r = w;
		j = 0;
		for (int p = 1; p <= `CODE_POSITIONS; p++) begin
			if ((p & (p - 1)) != 0) begin
				if (en && syn == p[`CHECK_BITS-1:0])
					r[j] = ~r[j];
				j++;
			end
		end
		return r;
	endfunction

	// Pin synchronisers; stage 2 is the first one any logic reads.
	logic [2:0]           k_sr_q, kn_sr_q, c_sr_q, cn_sr_q;
	logic [1:0]           rsel_sr_q, wsel_sr_q, zq_sr_q;
	logic [ADDR_BITS-1:0] addr_s1_q, addr_s2_q;
	logic [DW-1:0]        wd_s1_q, wd_s2_q;
	logic [LANES-1:0]     bw_s1_q, bw_s2_q;

	always_ff @(posedge i_sys_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			// Each clock stage resets to its pin's idle level, so release makes no false edge.
			k_sr_q    <= 3'h0;
			kn_sr_q   <= 3'h7;
			c_sr_q    <= 3'h7;
			cn_sr_q   <= 3'h7;
			rsel_sr_q <= 2'h3;
			wsel_sr_q <= 2'h3;
			zq_sr_q   <= 2'h0;
			addr_s1_q <= '0;
			addr_s2_q <= '0;
			wd_s1_q   <= '0;
			wd_s2_q   <= '0;
			bw_s1_q   <= '1;
			bw_s2_q   <= '1;
		end else begin
			k_sr_q    <= {k_sr_q[1:0], i_k};
			kn_sr_q   <= {kn_sr_q[1:0], i_k_n};
			c_sr_q    <= {c_sr_q[1:0], i_c};
			cn_sr_q   <= {cn_sr_q[1:0], i_c_n};
			rsel_sr_q <= {rsel_sr_q[0], i_read_sel_n};
			wsel_sr_q <= {wsel_sr_q[0], i_write_sel_n};
			zq_sr_q   <= {zq_sr_q[0], i_impedance_reference_pin};
			addr_s1_q <= i_addr;
			addr_s2_q <= addr_s1_q;
			wd_s1_q   <= i_write_data;
			wd_s2_q   <= wd_s1_q;
			bw_s1_q   <= i_byte_write_enable_n;
			bw_s2_q   <= bw_s1_q;
		end
	end

	logic k_rise, kn_rise, use_k, out_lo_ev, out_hi_ev;
	assign k_rise  = k_sr_q[1] & ~k_sr_q[2];
	assign kn_rise = kn_sr_q[1] & ~kn_sr_q[2];
	assign use_k   = c_sr_q[1] & cn_sr_q[1]; // R14
	assign out_lo_ev = use_k ? kn_rise : (cn_sr_q[1] & ~cn_sr_q[2]); // R14
	assign out_hi_ev = use_k ? k_rise : (c_sr_q[1] & ~c_sr_q[2]);

	// Write port. The write lands one cycle after the second beat.
	wr_state_t            wr_state_q;
	logic [DW-1:0]        wd0_q, wd1_q;
	logic [LANES-1:0]     bw0_q, bw1_q;
	logic [ADDR_BITS-1:0] waddr_q;
	logic                 ecc_off_q;
	logic [LANES-1:0]     half_lane;

	always_ff @(posedge i_sys_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			wr_state_q <= WR_IDLE;
			wd0_q      <= '0;
			wd1_q      <= '0;
			bw0_q      <= '1;
			bw1_q      <= '1;
			waddr_q    <= '0;
		end else begin
			case (wr_state_q)
				WR_IDLE, WR_COMMIT: begin
					wr_state_q <= WR_IDLE;
					if (k_rise && !wsel_sr_q[1]) begin // R12 R13
						wd0_q      <= wd_s2_q; // R1
						bw0_q      <= bw_s2_q; // R1
						wr_state_q <= WR_BEAT1;
					end
				end
				WR_BEAT1: begin
					if (kn_rise) begin // R12 R3
						wd1_q      <= wd_s2_q; // R1
						bw1_q      <= bw_s2_q; // R1
						waddr_q    <= addr_s2_q;
						wr_state_q <= WR_COMMIT;
					end
				end
				default: wr_state_q <= WR_IDLE;
			endcase
		end
	end

	always_ff @(posedge i_sys_clk or negedge i_resetn) begin
		if (!i_resetn)
			ecc_off_q <= 1'b0;
		else if (wr_state_q == WR_COMMIT && |half_lane)
			ecc_off_q <= 1'b1; // R5
	end

	// Read port: two-stage pipe on K, launched by the output clock pair, or by K# and K while both are held high.
	logic                 rd1_vld_q, rd2_vld_q, hold_vld_q;
	logic [ADDR_BITS-1:0] rd1_addr_q, rd2_addr_q;
	logic [DW-1:0]        rd_b0, rd_b1, hold_q;

	always_ff @(posedge i_sys_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			rd1_vld_q  <= 1'b0;
			rd2_vld_q  <= 1'b0;
			rd1_addr_q <= '0;
			rd2_addr_q <= '0;
		end else if (k_rise) begin // R10 R18
			rd1_vld_q  <= ~rsel_sr_q[1];
			rd1_addr_q <= addr_s2_q;
			rd2_vld_q  <= rd1_vld_q;
			rd2_addr_q <= rd1_addr_q;
		end
	end

	always_ff @(posedge i_sys_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			o_read_data      <= '0;
			o_read_data_oe_n <= 1'b1;
			hold_q           <= '0;
			hold_vld_q       <= 1'b0;
		end else if (out_lo_ev) begin
			o_read_data_oe_n <= ~rd2_vld_q; // R10 R11
			hold_vld_q       <= rd2_vld_q;
			if (rd2_vld_q) begin
				o_read_data <= rd_b0;
				hold_q      <= rd_b1;
			end
		end else if (out_hi_ev) begin
			o_read_data_oe_n <= ~hold_vld_q; // R10 R11
			hold_vld_q       <= 1'b0;
			if (hold_vld_q)
				o_read_data <= hold_q;
		end
	end

	// One storage lane per mask bit; beat 0 and beat 1 arrays stand for address bit 0.
	for (genvar l = 0; l < LANES; l++) begin : g_lane
		logic [`LANE_BITS-1:0]   beat0_mem [0:DEPTH-1];
		logic [`LANE_BITS-1:0]   beat1_mem [0:DEPTH-1];
		logic [`CHECK_BITS-1:0]  check_mem [0:DEPTH-1];
		logic [2*`LANE_BITS-1:0] old_word, new_word, rd_word;
		logic                    keep0, keep1;

		assign keep0 = bw0_q[l];
		assign keep1 = bw1_q[l];
		assign half_lane[l] = keep0 ^ keep1; // R5
		assign old_word = hamming_fix({beat1_mem[waddr_q], beat0_mem[waddr_q]},
			check_mem[waddr_q], ~ecc_off_q); // R17
		assign new_word[`LANE_BITS-1:0] = keep0 ? old_word[`LANE_BITS-1:0]
			: wd0_q[l*`LANE_BITS +: `LANE_BITS]; // R2 R6 R7
		assign new_word[2*`LANE_BITS-1:`LANE_BITS] = keep1 ? old_word[2*`LANE_BITS-1:`LANE_BITS]
			: wd1_q[l*`LANE_BITS +: `LANE_BITS]; // R2 R6 R7

		// A lane with both masks high is never touched, so its code stays valid.
		always_ff @(posedge i_sys_clk) begin
			if (wr_state_q == WR_COMMIT && !(keep0 && keep1)) begin // R4 R13
				beat0_mem[waddr_q] <= new_word[`LANE_BITS-1:0]; // R16
				beat1_mem[waddr_q] <= new_word[2*`LANE_BITS-1:`LANE_BITS]; // R16
				check_mem[waddr_q] <= hamming_check(new_word); // R15
			end
		end

		assign rd_word = hamming_fix({beat1_mem[rd2_addr_q], beat0_mem[rd2_addr_q]},
			check_mem[rd2_addr_q], ~ecc_off_q); // R15 R17
		assign rd_b0[l*`LANE_BITS +: `LANE_BITS] = rd_word[`LANE_BITS-1:0];
		assign rd_b1[l*`LANE_BITS +: `LANE_BITS] = rd_word[2*`LANE_BITS-1:`LANE_BITS];
	end

	// Output driver calibration. The reference pin high means the driver is too weak.
	logic [CW-1:0] imp_cnt_q;
	logic          imp_tick;
	assign imp_tick = (imp_cnt_q == CW'(IMP_PERIOD - 1));

	always_ff @(posedge i_sys_clk or negedge i_resetn) begin
		if (!i_resetn)
			imp_cnt_q <= '0;
		else if (imp_tick)
			imp_cnt_q <= '0; // R8
		else
			imp_cnt_q <= imp_cnt_q + 1'b1; // R8
	end

	always_ff @(posedge i_sys_clk or negedge i_resetn) begin
		if (!i_resetn)
			o_drive_setting <= `DRIVE_RESET;
		else if (imp_tick) begin
			if (zq_sr_q[1] && o_drive_setting != '1)
				o_drive_setting <= o_drive_setting + 1'b1; // R9
			else if (!zq_sr_q[1] && o_drive_setting != '0)
				o_drive_setting <= o_drive_setting - 1'b1; // R9
		end
	end

	always_ff @(posedge i_sys_clk or negedge i_resetn) begin
		if (!i_resetn)
			o_ecc_enabled <= 1'b1;
		else
			o_ecc_enabled <= ~ecc_off_q;
	end

	default clocking cb @(posedge i_sys_clk); endclocking
	default disable iff (!i_resetn);

	sequence s_second_beat;
		wr_state_q == WR_BEAT1 && kn_rise;
	endsequence
	sequence s_commit_once;
		wr_state_q == WR_COMMIT ##1 wr_state_q != WR_COMMIT;
	endsequence

	AST_WRITE_TWO_BEATS: assert property (s_second_beat |=> s_commit_once) // R3 R12
		else $error("second beat did not commit exactly one write");
	AST_HALF_WRITE_OFF: assert property (wr_state_q == WR_COMMIT && |half_lane ##1 1'b1
		|=> !o_ecc_enabled) // R5
		else $error("half write left ECC enabled");
	AST_ECC_STICKY: assert property (ecc_off_q |=> ecc_off_q [*8]) // R5
		else $error("ECC came back on");
	AST_DRIVE_ONE_STEP: assert property (o_drive_setting != $past(o_drive_setting) |->
		(o_drive_setting == $past(o_drive_setting) + 1'b1
		|| o_drive_setting == $past(o_drive_setting) - 1'b1)) // R9
		else $error("driver setting moved by more than one step");
	AST_DRIVE_ON_TICK: assert property (!$past(imp_tick) |-> $stable(o_drive_setting)) // R8
		else $error("driver setting changed outside an evaluation");
	AST_TICK_RESTART: assert property (imp_tick |=> imp_cnt_q == '0 ##1 imp_cnt_q == CW'(1)) // R8
		else $error("evaluation counter did not restart");
	AST_READ_DRIVES: assert property (out_lo_ev && rd2_vld_q |=> !o_read_data_oe_n
		&& o_read_data == $past(rd_b0)) // R10
		else $error("read beat 0 not driven");
	AST_DESELECT_HIZ: assert property (out_lo_ev && !rd2_vld_q |=> o_read_data_oe_n) // R11
		else $error("deselected read drove the outputs");
	AST_MASK_ABORT: assert property (wr_state_q == WR_COMMIT && &bw0_q && &bw1_q
		|=> ecc_off_q == $past(ecc_off_q)) // R13
		else $error("aborted write changed ECC state");
	AST_WRITE_IGNORED: assert property (wr_state_q != WR_BEAT1 && k_rise && wsel_sr_q[1]
		|=> wr_state_q == WR_IDLE) // R13
		else $error("deselected write started a transfer");
endmodule
`default_nettype wire

// ==== ddr_sram_ports_map.svh ====
// Constants for the DDR SRAM read and write ports: widths, ECC sizes, timing counts.
// Assumes inclusion by its bare name from the package and the port module.
`ifndef DDR_SRAM_PORTS_MAP_SVH
`define DDR_SRAM_PORTS_MAP_SVH

`define LANE_BITS        9
`define CHECK_BITS       5
`define CODE_POSITIONS   23
`define LANES_DEFAULT    2
`define ADDR_BITS        21
`define DRIVE_BITS       6
`define DRIVE_RESET      6'h20
`define IMP_PERIOD       1024

`endif

// ==== ddr_sram_ports_pkg.sv ====
// Types shared by the DDR SRAM port logic.
// Assumes the constant header sits in the same folder.
`include "ddr_sram_ports_map.svh"

package ddr_sram_ports_pkg;
	typedef enum logic [1:0] {
		WR_IDLE   = 2'b00,
		WR_BEAT1  = 2'b01,
		WR_COMMIT = 2'b10
	} wr_state_t;

	typedef logic [`DRIVE_BITS-1:0] drive_t;
endpackage

// ==== mem_ctrl_model.sv ====
// Memory controller model: drives the input clock pair, selects, address, data and lane masks.
// Assumes the port block samples every pin with its own much faster system clock.
`timescale 1ns/10ps
`default_nettype none
module mem_ctrl_model #(
	parameter int AW = 4
) (
	input  wire logic          i_sys_clk,
	input  wire logic [17:0]   i_read_data,
	input  wire logic          i_read_data_oe_n,
	input  wire logic          i_use_c,
	output var  logic          o_k,
	output var  logic          o_k_n,
	output var  logic          o_c,
	output var  logic          o_c_n,
	output var  logic          o_read_sel_n,
	output var  logic          o_write_sel_n,
	output var  logic [AW-1:0] o_addr,
	output var  logic [17:0]   o_write_data,
	output var  logic [1:0]    o_byte_write_enable_n,
	output var  logic [17:0]   o_beat0,
	output var  logic [17:0]   o_beat1,
	output var  logic [1:0]    o_oe_n
);
	initial begin
		o_k = 1'b0;
		o_k_n = 1'b1;
		o_c = 1'b1;
		o_c_n = 1'b1;
		o_read_sel_n = 1'b1;
		o_write_sel_n = 1'b1;
		o_addr = '0;
		o_write_data = '0;
		o_byte_write_enable_n = 2'h3;
	end

	// One K period is 16 system cycles, so every pin stays put 4 cycles either side of its rise.
	// With i_use_c low the output clocks stay high and beats are sampled 6 cycles after the
	// K# and K rises. With i_use_c high C and C# trail K and K# by 4 cycles, and beat 0 is
	// sampled after the K rise, so outputs still timed by K would be caught.
	task automatic kcycle(input logic rd_n, input logic [AW-1:0] ra, input logic wr_n,
		input logic [AW-1:0] wa, input logic [17:0] d0, input logic [17:0] d1,
		input logic [1:0] m0, input logic [1:0] m1);
		@(posedge i_sys_clk);
		o_read_sel_n <= rd_n;
		o_write_sel_n <= wr_n;
		o_addr <= ra;
		o_write_data <= d0;
		o_byte_write_enable_n <= m0;
		if (i_use_c) begin
			o_c <= 1'b0;
			o_c_n <= 1'b1;
		end
		repeat (2) @(posedge i_sys_clk);
		if (!i_use_c) begin
			o_beat0 <= i_read_data;
			o_oe_n[0] <= i_read_data_oe_n;
		end
		repeat (2) @(posedge i_sys_clk);
		o_k <= 1'b1;
		o_k_n <= 1'b0;
		repeat (4) @(posedge i_sys_clk);
		o_addr <= wa;
		o_write_data <= d1;
		o_byte_write_enable_n <= m1;
		if (i_use_c) begin
			o_c <= 1'b1;
			o_c_n <= 1'b0;
		end
		repeat (2) @(posedge i_sys_clk);
		if (i_use_c) begin
			o_beat0 <= i_read_data;
			o_oe_n[0] <= i_read_data_oe_n;
		end else begin
			o_beat1 <= i_read_data;
			o_oe_n[1] <= i_read_data_oe_n;
		end
		repeat (2) @(posedge i_sys_clk);
		o_k <= 1'b0;
		o_k_n <= 1'b1;
		repeat (2) @(posedge i_sys_clk);
		if (i_use_c) begin
			o_beat1 <= i_read_data;
			o_oe_n[1] <= i_read_data_oe_n;
		end
		@(posedge i_sys_clk);
	endtask
endmodule
`default_nettype wire

// ==== tb_top.sv ====
// Testbench for the DDR SRAM port block: writes, lane masks, reads, deselects, drive steps.
// Assumes the port design and the controller model are compiled before it.
`timescale 1ns/10ps
`default_nettype none
module tb_top;
	import ddr_sram_ports_pkg::*;
	localparam logic [17:0] P0 = 18'h2A5C3;
	localparam logic [17:0] P1 = 18'h15A3C;
	localparam logic [17:0] Q0 = 18'h0F0F0;
	localparam logic [17:0] Q1 = 18'h30F0F;
	logic        clk;
	logic        resetn;
	logic        zq;
	logic        k, k_n, rd_n, wr_n, oe_n, ecc;
	logic        oc, oc_n, use_c;
	logic [3:0]  addr;
	logic [17:0] wdata, rdata, b0, b1;
	logic [1:0]  mask, oe2;
	drive_t      drive;
	int          failures = 0;
	int          num_checks = 0;
	int          cycles = 0;

	ddr_sram_byte_write_ports #(.LANES(2), .ADDR_BITS(4), .IMP_PERIOD(8)) DUT (
		.i_sys_clk(clk), .i_resetn(resetn), .i_k(k), .i_k_n(k_n),
		.i_c(oc), .i_c_n(oc_n),
		.i_read_sel_n(rd_n), .i_write_sel_n(wr_n), .i_addr(addr), .i_write_data(wdata),
		.i_byte_write_enable_n(mask), .i_impedance_reference_pin(zq), .o_read_data(rdata),
		.o_read_data_oe_n(oe_n), .o_drive_setting(drive), .o_ecc_enabled(ecc));

	mem_ctrl_model #(.AW(4)) M (
		.i_sys_clk(clk), .i_read_data(rdata), .i_read_data_oe_n(oe_n), .i_use_c(use_c),
		.o_k(k), .o_k_n(k_n), .o_c(oc), .o_c_n(oc_n),
		.o_read_sel_n(rd_n), .o_write_sel_n(wr_n), .o_addr(addr), .o_write_data(wdata),
		.o_byte_write_enable_n(mask), .o_beat0(b0), .o_beat1(b1), .o_oe_n(oe2));

	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end

	task automatic report_and_stop();
		$display("checks=%0d failures=%0d", num_checks, failures);
		if (failures == 0 && num_checks > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask

	// The whole run needs under 2000 cycles, so this only trips on a hang.
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 4000) begin
			failures++;
			report_and_stop();
		end
	end

	task automatic chk(input logic [17:0] got, input logic [17:0] exp);
		num_checks++;
		if (got !== exp) begin
			failures++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic rdchk(input logic [17:0] e0, input logic [17:0] e1);
		chk(b0, e0);
		chk(b1, e1);
		chk({16'h0000, oe2}, 18'h00000);
	endtask

	task automatic idle();
		M.kcycle(1'b1, 4'h0, 1'b1, 4'h0, 18'h3FFFF, 18'h00000, 2'h3, 2'h3);
	endtask

	function automatic logic [17:0] merge(input logic [17:0] nw, input logic [17:0] old,
		input logic [1:0] m);
		logic [17:0] keep;
		keep = {{9{m[1]}}, {9{m[0]}}};
		return (nw & ~keep) | (old & keep);
	endfunction

	task automatic t_drive(input logic lvl);
		drive_t v;
		int     n;
		n = 0;
		@(posedge clk);
		zq <= lvl;
		repeat (24) @(posedge clk);
		#1 v = drive;
		while (drive === v && n < 20) begin
			@(posedge clk);
			#1 n++;
		end
		v = drive;
		repeat (7) @(posedge clk);
		#1 chk({12'h000, drive}, {12'h000, v});
		@(posedge clk);
		#1 chk({12'h000, drive}, {12'h000, lvl ? v + 6'h01 : v - 6'h01});
		$display("test drive step done");
	endtask

	task automatic t_basic();
		M.kcycle(1'b1, 4'h0, 1'b0, 4'h5, P0, P1, 2'h0, 2'h0);
		M.kcycle(1'b0, 4'h5, 1'b0, 4'h6, Q0, Q1, 2'h0, 2'h0);
		M.kcycle(1'b0, 4'h6, 1'b0, 4'h5, ~P0, ~P1, 2'h3, 2'h3);
		chk({16'h0000, oe2}, 18'h00003);
		M.kcycle(1'b0, 4'h5, 1'b1, 4'h6, ~Q0, ~Q1, 2'h0, 2'h0);
		rdchk(P0, P1);
		M.kcycle(1'b0, 4'h6, 1'b1, 4'h0, P1, P0, 2'h0, 2'h0);
		rdchk(Q0, Q1);
		idle();
		rdchk(P0, P1);
		idle();
		rdchk(Q0, Q1);
		chk({17'h00000, ecc}, 18'h00001);
		$display("test basic done");
	endtask

	// Equal mask pairs come first, so whole-lane masking and abort are seen with ECC still on.
	task automatic t_masks();
		logic [1:0] m0, m1, x;
		logic       ecc_exp;
		ecc_exp = 1'b1;
		for (int c = 0; c < 16; c++) begin
			{x, m0} = 4'(c);
			m1 = m0 ^ x;
			ecc_exp &= (m0 == m1);
			M.kcycle(1'b1, 4'h0, 1'b0, 4'h9, P0, P1, 2'h0, 2'h0);
			M.kcycle(1'b1, 4'h0, 1'b0, 4'h9, Q0, Q1, m0, m1);
			M.kcycle(1'b0, 4'h9, 1'b1, 4'h0, ~Q0, ~Q1, 2'h3, 2'h3);
			idle();
			idle();
			chk(b0, merge(Q0, P0, m0));
			chk(b1, merge(Q1, P1, m1));
			chk({16'h0000, oe2}, 18'h00000);
			chk({17'h00000, ecc}, {17'h00000, ecc_exp});
		end
		$display("test lane masks done");
	endtask

	// The output clocks start toggling only here, after every K-timed beat has drained.
	task automatic t_cclk();
		@(posedge clk);
		use_c <= 1'b1;
		M.kcycle(1'b1, 4'h0, 1'b0, 4'hC, Q1, Q0, 2'h0, 2'h0);
		M.kcycle(1'b0, 4'hC, 1'b1, 4'h0, P0, P1, 2'h0, 2'h0);
		idle();
		idle();
		rdchk(Q1, Q0);
		idle();
		chk({16'h0000, oe2}, 18'h00003);
		$display("test output clocks done");
	endtask

	initial begin
		resetn = 1'b0;
		zq = 1'b0;
		use_c = 1'b0;
		repeat (10) @(posedge clk);
		chk({10'h000, ecc, oe_n, drive}, 18'h000E0);
		resetn <= 1'b1;
		t_drive(1'b0);
		t_drive(1'b1);
		t_basic();
		t_masks();
		t_cclk();
		report_and_stop();
	end
endmodule
`default_nettype wire
